/* hw/swat_translator.sv */
// Store word address translator with its 128-word store and register slave.
// Assumes the message, scan and lamp inputs come from logic on clk.
// Contract
// (R1) Drive one-hot 16 row and 8 column lines; their crossing picks one word.
// (R2) Select from slot counters, message address, attendant or scan counter.
// (R3) A slot: low three bits pick column, high two pick rows 0-3.
// (R4) B slot: low three bits pick column, next two pick rows 4-7.
// (R5) Relocation: three bits pick column; two bits plus half bit pick row.
// (R6) Message path reaches only talking words 2-31 and 34-63.
// (R7) Scanner slot: scan bits give column and one of rows 8-12.
// (R8) Spare slot A1 without relocation selects row 13, column 0, word 104.
// (R9) Slot A0 with lamp gate selects lamp words 112-127.
// (R10) Store holds 128 words of 32 bits in an 8 by 16 grid.
// (R11) Columns 0-3 form one 64-word half, columns 4-7 the other.
// (R12) Words 0 and 1 hold incoming message bits, reached in slot B32; the code selects only word 0 in B32, and word 1 is never selected.
// (R13) Words 2-31 serve slots A2-A31, words 34-63 slots B2-B31.
// (R14) Words 32 and 33 serve maintenance scan and outgoing bits with B0.
// (R15) Words 64-103 hold scan point states; 104-111 are spares.
// (R16) Talking words cycle once per cycle with one scan and lamp word.
// (R17) A and B counters advance alternately on P3; A wraps 31, B after 32.
// (R18) A slot gate spans P7 through P6, B gate the next interval.
// (R19) One source per slot; no source gives no row or column line.
`timescale 1ns/1ps
`default_nettype none
`include "swat_map.svh"
module swat_translator
  import swat_pkg::*;
#(
  parameter int PULSE_CYC = `SWAT_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] msg_addr_reg,
  input wire logic msg_reloc_idle_t,
  input wire logic msg_reloc_idle_l,
  input wire logic scanner_slot_gate,
  input wire logic spare_slot_gate,
  input wire logic lamp_slot_gate,
  input wire logic [5:0] scan_count,
  input wire logic [3:0] lamp_count,
  output logic a_slot_gate,
  output logic b_slot_gate,
  output logic [15:0] row_select_line,
  output logic [7:0] column_select_line,
  output logic [31:0] store_word,
  output logic store_word_valid
);

  logic [4:0] a_count;
  logic [5:0] b_count;
  logic slot_start;
  swat_src_type src_next, src_reg;
  logic [3:0] row_idx;
  logic [2:0] col_idx;
  logic reloc_busy, msg_ok, sel_en;
  logic [3:0] msg_row;
  logic [2:0] msg_col;
  logic [15:0] row_dec, row_reg, row_next;
  logic [7:0] col_dec, col_reg, col_next;
  logic [6:0] word_reg, word_next;
  logic word_valid_reg, word_valid_next;
  logic [31:0] out_reg, out_next;
  logic out_valid_reg, out_valid_next;
  logic [31:0] mem_reg [0:`SWAT_WORDS-1];

  swat_slot_counter #(.PULSE_CYC(PULSE_CYC)) u_slots (
    .clk(clk),
    .rst(rst),
    .a_count(a_count),
    .b_count(b_count),
    .a_slot_gate(a_slot_gate),
    .b_slot_gate(b_slot_gate),
    .slot_start(slot_start)
  );

  // Register slave state
  logic ctrl_en_reg, ctrl_en_next;
  logic [6:0] index_reg, index_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, status_word;
  logic mem_we, do_write;
  logic [31:0] mem_wdata;

  // Message address fields: half bit picks the row group [R5]
  assign reloc_busy = !(msg_reloc_idle_t && msg_reloc_idle_l);
  assign msg_col = {msg_addr_reg[3], msg_addr_reg[2], msg_addr_reg[0]};
  assign msg_row = {1'b0, msg_addr_reg[1], msg_addr_reg[5:4]};
  // Words 0, 1, 32, 33 are not talking words and stay unreachable [R6]
  assign msg_ok = ({msg_row[1:0], msg_col} >= 5'h02);

  // Source choice for the coming slot, one source at most [R2] [R19]
  always_comb begin
    src_next = SWAT_SRC_NONE;
    row_idx = 4'h0;
    col_idx = 3'h0;
    if (ctrl_en_reg && a_slot_gate) begin
      if (a_count == 5'h00) begin
        if (lamp_slot_gate) begin
          src_next = SWAT_SRC_LAMP; // [R9]
          col_idx = lamp_count[2:0];
          row_idx = lamp_count[3] ? `SWAT_ROW_LAMP_HI : `SWAT_ROW_LAMP;
        end
      end else if (a_count == 5'h01) begin
        if (spare_slot_gate && !reloc_busy) begin
          src_next = SWAT_SRC_SPARE; // [R8]
          row_idx = `SWAT_ROW_SPARE;
        end else if (reloc_busy && msg_ok) begin
          src_next = SWAT_SRC_MSG; // [R5] [R6]
          row_idx = msg_row;
          col_idx = msg_col;
        end
      end else begin
        src_next = SWAT_SRC_A; // [R3] [R13]
        row_idx = {2'b00, a_count[4:3]};
        col_idx = a_count[2:0];
      end
    end else if (ctrl_en_reg && b_slot_gate) begin
      if (b_count == `SWAT_B_LAST) begin
        src_next = SWAT_SRC_INMSG; // Incoming bits sit in word 0 [R12]
      end else if (b_count == 6'h01 && scanner_slot_gate) begin
        // Rows above 12 do not exist in the scan area [R7] [R15]
        if (scan_count[5:3] < `SWAT_SCAN_ROWS) begin
          src_next = SWAT_SRC_SCAN;
          row_idx = 4'(`SWAT_ROW_SCAN + {1'b0, scan_count[5:3]});
          col_idx = scan_count[2:0];
        end
      end else begin
        // B0 lands on word 32, B1 on 33 when the scanner gate is low [R4] [R13] [R14]
        src_next = SWAT_SRC_B;
        row_idx = {2'b01, b_count[4:3]};
        col_idx = b_count[2:0];
      end
    end
  end

  assign sel_en = (src_next != SWAT_SRC_NONE);

  // Row and column decode: one line of each group at most [R1]
  swat_onehot #(.IW(4), .OW(`SWAT_ROWS)) u_row_dec (
    .en(sel_en),
    .idx(row_idx),
    .lines(row_dec)
  );
  swat_onehot #(.IW(3), .OW(`SWAT_COLS)) u_col_dec (
    .en(sel_en),
    .idx(col_idx),
    .lines(col_dec)
  );

  // Selection latched at slot start so lines stay still for the slot
  always_comb begin
    row_next = row_reg;
    col_next = col_reg;
    word_next = word_reg;
    word_valid_next = word_valid_reg;
    out_next = out_reg;
    out_valid_next = 1'b0;
    if (slot_start) begin
      row_next = row_dec;
      col_next = col_dec;
      word_next = {row_idx, col_idx}; // Word = row * 8 + column [R10]
      word_valid_next = sel_en;
      if (sel_en) begin
        out_next = mem_reg[{row_idx, col_idx}]; // [R16]
        out_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      row_reg <= 16'h0000;
      col_reg <= 8'h00;
      word_reg <= 7'h00;
      word_valid_reg <= 1'b0;
      src_reg <= SWAT_SRC_NONE;
      out_reg <= 32'h0000_0000;
      out_valid_reg <= 1'b0;
    end else begin
      row_reg <= row_next;
      col_reg <= col_next;
      word_reg <= word_next;
      word_valid_reg <= word_valid_next;
      src_reg <= slot_start ? src_next : src_reg;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
    end
  end

  assign row_select_line = row_reg;
  assign column_select_line = col_reg;
  assign store_word = out_reg;
  assign store_word_valid = out_valid_reg;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] swat_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Status half bit carries column select line 2, high only while column 2 is selected [R11]
  assign status_word = {7'h00, col_reg[2], 2'b00, b_count, 3'h0, a_count,
    word_valid_reg, word_reg};

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // Write and read channels; address and data may come in either order
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    ctrl_en_next = ctrl_en_reg;
    index_next = index_reg;
    mem_we = 1'b0;
    mem_wdata = swat_merge(mem_reg[index_reg], wdata_reg, wstrb_reg);
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `SWAT_RESP_OKAY;
      case (awaddr_reg)
        `SWAT_OFF_CTRL: begin
          if (wstrb_reg[0]) ctrl_en_next = wdata_reg[0];
        end
        `SWAT_OFF_INDEX: begin
          if (wstrb_reg[0]) index_next = wdata_reg[6:0];
        end
        `SWAT_OFF_DATA: mem_we = 1'b1;
        `SWAT_OFF_STATUS: ;
        default: bresp_next = `SWAT_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `SWAT_RESP_OKAY;
      case (s_axi_araddr)
        `SWAT_OFF_CTRL: rdata_next = {31'h0, ctrl_en_reg};
        `SWAT_OFF_STATUS: rdata_next = status_word;
        `SWAT_OFF_INDEX: rdata_next = {25'h0, index_reg};
        `SWAT_OFF_DATA: rdata_next = mem_reg[index_reg];
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `SWAT_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SWAT_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `SWAT_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      ctrl_en_reg <= `SWAT_CTRL_RESET;
      index_reg <= 7'h00;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_en_reg <= ctrl_en_next;
      index_reg <= index_next;
    end
  end

  // Store array: content is not reset, software loads it [R10]
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_reg[index_reg] <= mem_wdata;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Checks on the translator's own outputs
  default clocking swat_cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence a_talk_start;
    slot_start && ctrl_en_reg && a_slot_gate && a_count >= 5'h02;
  endsequence
  sequence b_talk_start;
    slot_start && ctrl_en_reg && b_slot_gate && b_count >= 6'h02
      && b_count < `SWAT_B_LAST;
  endsequence
  sequence spare_start;
    slot_start && ctrl_en_reg && a_slot_gate && a_count == 5'h01
      && spare_slot_gate && msg_reloc_idle_t && msg_reloc_idle_l;
  endsequence
  // Enable sampled in the slot start cycle itself, as the selection uses it
  sequence off_start;
    slot_start && !ctrl_en_reg;
  endsequence

  row_onehot_a: assert property ($onehot0(row_select_line)) // [R1]
    else $error("row lines not one-hot");
  row_col_pair_a: assert property ( // [R1]
    (row_select_line != 16'h0) == (column_select_line != 8'h00))
    else $error("row and column selects unpaired");
  a_slot_map_a: assert property (a_talk_start |=> // [R3]
    row_select_line == (16'h0001 << $past(a_count[4:3]))
    && column_select_line == (8'h01 << $past(a_count[2:0])))
    else $error("A slot word mismatch");
  b_slot_map_a: assert property (b_talk_start |=> // [R4]
    row_select_line == (16'h0010 << $past(b_count[4:3]))
    && column_select_line == (8'h01 << $past(b_count[2:0])))
    else $error("B slot word mismatch");
  msg_reach_a: assert property (src_reg == SWAT_SRC_MSG |-> // [R6]
    word_reg >= 7'h02 && word_reg <= 7'h3f && word_reg != 7'h20
    && word_reg != 7'h21)
    else $error("message path reached a non-talking word");
  scan_rows_a: assert property (src_reg == SWAT_SRC_SCAN |-> // [R7]
    (row_select_line & 16'he0ff) == 16'h0000 && word_reg >= 7'h40)
    else $error("scan select outside rows 8 to 12");
  spare_word_a: assert property (spare_start |=> // [R8]
    word_reg == 7'h68 && word_valid_reg && column_select_line == 8'h01)
    else $error("spare slot did not select word 104");
  lamp_word_a: assert property ( // [R9]
    src_reg == SWAT_SRC_LAMP |-> word_reg >= 7'h70 && word_valid_reg)
    else $error("lamp select outside words 112 to 127");
  a_wrap_a: assert property ($changed(a_count) |-> // [R17]
    a_count == (($past(a_count) == 5'h1f) ? 5'h00 : $past(a_count) + 5'h01))
    else $error("A counter stepped wrongly");
  b_limit_a: assert property (b_count <= `SWAT_B_LAST) // [R17]
    else $error("B counter passed 32");
  gates_excl_a: assert property (!(a_slot_gate && b_slot_gate)) // [R18]
    else $error("both slot gates active");
  off_quiet_a: assert property (off_start |=> // [R19]
    row_select_line == 16'h0000 && column_select_line == 8'h00)
    else $error("lines driven with translator off");

endmodule
`default_nettype wire

/* hw/swat_map.svh */
// Constants of the store word address translator: timing, map and offsets.
// Included by the translator and slot counter files; holds definitions only.
`ifndef SWAT_MAP_SVH
`define SWAT_MAP_SVH

// Clock and store clock pulse timing
`define SWAT_CLK_NS 25
`define SWAT_PULSE_NS 145
`define SWAT_PULSE_CYC (`SWAT_PULSE_NS / `SWAT_CLK_NS)
`define SWAT_LAST_PHASE 4'h9
`define SWAT_PH_BEFORE_P3 4'h2
`define SWAT_PH_BEFORE_P7 4'h6

// Slot counter limits
`define SWAT_A_LAST 5'h1f
`define SWAT_B_LAST 6'h20

// Store geometry and word map rows
`define SWAT_WORDS 128
`define SWAT_WIDTH 32
`define SWAT_ROWS 16
`define SWAT_COLS 8
`define SWAT_ROW_SCAN 4'h8
`define SWAT_SCAN_ROWS 3'h5
`define SWAT_ROW_SPARE 4'hd
`define SWAT_ROW_LAMP 4'he
`define SWAT_ROW_LAMP_HI 4'hf

// Register offsets (byte addresses) and reset values
`define SWAT_OFF_CTRL 12'h000
`define SWAT_OFF_STATUS 12'h004
`define SWAT_OFF_INDEX 12'h008
`define SWAT_OFF_DATA 12'h00c
`define SWAT_CTRL_RESET 1'b1

// Status field positions
`define SWAT_ST_IDX_LSB 0
`define SWAT_ST_VALID_BIT 7
`define SWAT_ST_A_LSB 8
`define SWAT_ST_B_LSB 16
`define SWAT_ST_HALF_BIT 24

// AXI responses
`define SWAT_RESP_OKAY 2'h0
`define SWAT_RESP_SLVERR 2'h2

`endif

/* hw/swat_pkg.sv */
// Types shared by the store word address translator design files.
// Assumes nothing of its surroundings.
package swat_pkg;

  // Which source drove the word select in the current slot
  typedef enum logic [2:0] {
    SWAT_SRC_NONE  = 3'b000,
    SWAT_SRC_A     = 3'b001,
    SWAT_SRC_B     = 3'b010,
    SWAT_SRC_MSG   = 3'b011,
    SWAT_SRC_SCAN  = 3'b100,
    SWAT_SRC_SPARE = 3'b101,
    SWAT_SRC_LAMP  = 3'b110,
    SWAT_SRC_INMSG = 3'b111
  } swat_src_type;

endpackage

/* hw/swat_onehot.sv */
// One-hot line decoder used for the row and the column select groups.
// Assumes idx stays below OW whenever en is high.
`timescale 1ns/1ps
`default_nettype none
module swat_onehot #(
  parameter int IW = 3,
  parameter int OW = 8
) (
  input wire logic en,
  input wire logic [IW-1:0] idx,
  output logic [OW-1:0] lines
);

  // Exactly one line when enabled, none otherwise
  always_comb begin
    lines = '0;
    if (en) begin
      lines[idx] = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* hw/swat_slot_counter.sv */
// Store clock pulse phases and the alternating A and B time slot counters.
// Assumes a free-running clk; all timing comes from one divider enable.
`timescale 1ns/1ps
`default_nettype none
`include "swat_map.svh"
module swat_slot_counter #(
  parameter int PULSE_CYC = `SWAT_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  output logic [4:0] a_count,
  output logic [5:0] b_count,
  output logic a_slot_gate,
  output logic b_slot_gate,
  output logic slot_start
);

  logic [7:0] div_reg, div_next;
  logic [3:0] phase_reg, phase_next;
  logic [4:0] a_reg, a_next;
  logic [5:0] b_reg, b_next;
  logic turn_reg, turn_next;
  logic gate_a_reg, gate_a_next;
  logic gate_on_reg, gate_on_next;
  logic start_reg, start_next;
  logic pulse;

  assign pulse = (div_reg == 8'(PULSE_CYC - 1));

  // Divider, nine-phase pulse ring and counters advanced on P3
  always_comb begin
    div_next = pulse ? 8'h00 : div_reg + 8'h01;
    phase_next = phase_reg;
    a_next = a_reg;
    b_next = b_reg;
    turn_next = turn_reg;
    gate_a_next = gate_a_reg;
    gate_on_next = gate_on_reg;
    start_next = 1'b0;
    if (pulse) begin
      phase_next = (phase_reg == `SWAT_LAST_PHASE) ? 4'h1 : phase_reg + 4'h1;
      // Counters take turns; the one advanced owns the next window [R17] [R16]
      if (phase_reg == `SWAT_PH_BEFORE_P3) begin
        turn_next = ~turn_reg;
        if (!turn_reg) begin
          a_next = (a_reg == `SWAT_A_LAST) ? 5'h00 : a_reg + 5'h01;
        end else begin
          b_next = (b_reg == `SWAT_B_LAST) ? 6'h00 : b_reg + 6'h01;
        end
      end
      // Window opens at P7 and holds through the following P6 [R18]
      if (phase_reg == `SWAT_PH_BEFORE_P7) begin
        gate_a_next = turn_reg;
        gate_on_next = 1'b1;
        start_next = 1'b1;
      end
    end
  end

  // Counters start at their last value so the first advance gives zero
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      phase_reg <= 4'h1;
      a_reg <= `SWAT_A_LAST;
      b_reg <= `SWAT_B_LAST;
      turn_reg <= 1'b0;
      gate_a_reg <= 1'b0;
      gate_on_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
      a_reg <= a_next;
      b_reg <= b_next;
      turn_reg <= turn_next;
      gate_a_reg <= gate_a_next;
      gate_on_reg <= gate_on_next;
      start_reg <= start_next;
    end
  end

  assign a_count = a_reg;
  assign b_count = b_reg;
  assign a_slot_gate = gate_on_reg && gate_a_reg;
  assign b_slot_gate = gate_on_reg && !gate_a_reg;
  assign slot_start = start_reg;

endmodule
`default_nettype wire

/* tb/swat_store_model.sv */
// Behavioural store array: turns the select lines into a word number.
// Assumes the lines come straight from the translator on the same clock.
`timescale 1ns/1ps
`default_nettype none
module swat_store_model (
  input wire logic [15:0] row_select_line,
  input wire logic [7:0] column_select_line,
  output logic [6:0] word_idx,
  output logic sel_one,
  output logic sel_none
);
  // Word is row*8+column; two rows at once would fight in the diodes
  always_comb begin
    word_idx = 7'h00;
    for (int i = 0; i < 16; i++) begin
      if (row_select_line[i]) word_idx[6:3] = i[3:0];
    end
    for (int j = 0; j < 8; j++) begin
      if (column_select_line[j]) word_idx[2:0] = j[2:0];
    end
    sel_one = $onehot(row_select_line) && $onehot(column_select_line);
    sel_none = (row_select_line == 16'h0000) && (column_select_line == 8'h00);
  end
endmodule
`default_nettype wire

/* tb/swat_translator_tb.sv */
// Self-checking bench for the store word address translator.
// Assumes a one-clock pulse divider, so one slot lasts nine clocks.
`timescale 1ns/1ps
`default_nettype none
module swat_translator_tb;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, store_word, lamp_seen, d;
  logic [3:0] s_axi_wstrb, lamp_count;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, msg_reloc_idle_t, msg_reloc_idle_l;
  logic scanner_slot_gate, spare_slot_gate, lamp_slot_gate;
  logic a_slot_gate, b_slot_gate, store_word_valid, sel_one, sel_none;
  logic [5:0] msg_addr_reg, scan_count;
  logic [15:0] row_select_line;
  logic [7:0] column_select_line;
  logic [6:0] word_idx;
  logic a_was = 1'b0, b_was = 1'b0, rec_en = 1'b0;
  int mismatches, checked, cycles, hold, skip, nrec;
  int hist_a[128], hist_b[128], exp_a[128], exp_b[128];

  swat_translator #(.PULSE_CYC(1)) swat_translator_inst (.clk, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_addr_reg,
    .msg_reloc_idle_t, .msg_reloc_idle_l, .scanner_slot_gate,
    .spare_slot_gate, .lamp_slot_gate, .scan_count, .lamp_count,
    .a_slot_gate, .b_slot_gate, .row_select_line, .column_select_line,
    .store_word, .store_word_valid);
  swat_store_model swat_store_model_inst (.row_select_line,
    .column_select_line, .word_idx, .sel_one, .sel_none);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Timeout, and a mid-slot sampler: lines settle a clock after the gate
  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      mismatches++;
      tally_and_finish();
    end
    if ((a_slot_gate && !a_was) || (b_slot_gate && !b_was)) hold = 5;
    else if (hold > 0) hold--;
    a_was = a_slot_gate;
    b_was = b_slot_gate;
    // Word valid pulses in the first cycle the new lines stand
    if (hold == 4 && rec_en) begin
      chk("word valid", sel_one, store_word_valid);
    end
    if (hold == 1 && rec_en) begin
      if (!sel_one && !sel_none) chk("one-hot lines", 1, 0);
      // Start on a B slot: 65 slots then hold 33 B and 32 A slots
      if (skip > 0) skip--;
      else if (nrec > 0 || !a_slot_gate) begin
        nrec++;
        if (sel_one && a_slot_gate) hist_a[word_idx]++;
        if (sel_one && !a_slot_gate) hist_b[word_idx]++;
        if (sel_one && word_idx == 7'h7b) lamp_seen = store_word;
      end
    end
  end

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic aw, w, ta, tw;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      #1 ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) aw = 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) w = 1'b0;
    end
    do begin
      #1 ta = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end while (!ta);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    logic t;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1 t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      #1 t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask

  // One full 65-slot cycle under fixed side inputs, against the word map
  task automatic run_cycle(input logic lg, logic [3:0] lc, logic sp, logic it,
      logic [5:0] ma, logic sg, logic [5:0] sc, logic en);
    logic [6:0] mw;
    mw = {1'b0, ma[1], ma[5:4], ma[3], ma[2], ma[0]};
    for (int i = 0; i < 128; i++) begin
      exp_a[i] = 0;
      exp_b[i] = 0;
      hist_a[i] = 0;
      hist_b[i] = 0;
    end
    if (en) begin
      for (int i = 2; i < 32; i++) begin
        exp_a[i] = 1;
        exp_b[i+32] = 1;
      end
      exp_b[0] = 1;
      exp_b[32] = 1;
      if (lg) exp_a[{3'h7, lc}]++;
      if (sp && it) exp_a[104]++;
      else if (!it && mw[4:1] != 4'h0) exp_a[mw]++;
      if (!sg) exp_b[33]++;
      else if (sc[5:3] < 3'h5) exp_b[64+sc]++;
    end
    @(posedge clk);
    lamp_slot_gate <= lg;
    lamp_count <= lc;
    spare_slot_gate <= sp;
    msg_reloc_idle_t <= it;
    msg_reloc_idle_l <= it;
    msg_addr_reg <= ma;
    scanner_slot_gate <= sg;
    scan_count <= sc;
    skip = 2;
    nrec = 0;
    rec_en = 1'b1;
    while (nrec < 65) @(posedge clk);
    rec_en = 1'b0;
    for (int i = 0; i < 128; i++) begin
      chk($sformatf("a-slot word %0d", i), exp_a[i], hist_a[i]);
      chk($sformatf("b-slot word %0d", i), exp_b[i], hist_b[i]);
    end
    $display("test slot cycle done, mismatches %0d", mismatches);
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {msg_addr_reg, scan_count, lamp_count} = '0;
    {scanner_slot_gate, spare_slot_gate, lamp_slot_gate} = '0;
    {msg_reloc_idle_t, msg_reloc_idle_l} = 2'h3;
    repeat (5) @(posedge clk);
    #1 chk("lines in reset", 32'h0,
      {8'h00, row_select_line, column_select_line});
    @(posedge clk);
    rst <= 1'b0;
    axi_rd(12'h000);
    chk("ctrl reset", 32'h1, d);
    chk("read resp", 32'h0, r);
    axi_wr(12'h008, 32'h7b);
    chk("write resp", 32'h0, r);
    axi_wr(12'h00c, 32'ha5c30f1e);
    axi_rd(12'h00c);
    chk("store data", 32'ha5c30f1e, d);
    axi_rd(12'h010);
    chk("unmapped resp", 32'h2, r);
    chk("unmapped data", 32'h0, d);
    $display("test registers done, mismatches %0d", mismatches);
    run_cycle(1'b1, 4'hb, 1'b1, 1'b1, 6'h00, 1'b1, 6'h1a, 1'b1);
    chk("lamp word read", 32'ha5c30f1e, lamp_seen);
    run_cycle(1'b0, 4'h0, 1'b0, 1'b1, 6'h00, 1'b0, 6'h00, 1'b1);
    run_cycle(1'b0, 4'h5, 1'b1, 1'b0, 6'h2b, 1'b1, 6'h2f, 1'b1);
    run_cycle(1'b1, 4'h0, 1'b0, 1'b0, 6'h1c, 1'b1, 6'h27, 1'b1);
    axi_rd(12'h004);
    chk("status half", d[2], d[24]);
    run_cycle(1'b0, 4'h0, 1'b0, 1'b0, 6'h03, 1'b0, 6'h00, 1'b1);
    axi_wr(12'h000, 32'h0);
    run_cycle(1'b1, 4'h3, 1'b1, 1'b1, 6'h00, 1'b1, 6'h01, 1'b0);
    axi_rd(12'h004);
    chk("status valid", 32'h0, d[7]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
